// file: hw/fnd_device.sv
// Device end: serial load port, latches, dividers, interpolator and monitor.
`timescale 1ns/10ps
module fnd_device (
  input  wire logic  sys_clk,            // System clock.
  input  wire logic  arst_n,             // Asynchronous reset, active low.
  fnd_link_if.device link,               // Serial load link.
  input  wire logic  referenceInput,     // Reference input pin.
  input  wire logic  feedbackInput,      // RF feedback input pin.
  output logic       detectorRef,        // Divided reference to the detector.
  output logic       detectorFb,         // Divided feedback to the detector.
  output logic       monitorOutput,      // Monitor output.
  output logic       refInputIsolated    // High while the reference pin is isolated.
);
  // Whole device state, registered in one place.
  typedef struct packed {
    logic [1:0]  sckS;       // Serial clock synchroniser.
    logic [1:0]  datS;       // Serial data synchroniser.
    logic [1:0]  leS;        // Latch strobe synchroniser.
    logic [1:0]  refS;       // Reference pin synchroniser.
    logic [1:0]  fbS;        // Feedback pin synchroniser.
    logic        sckD;       // Serial clock, one cycle later.
    logic        leD;        // Latch strobe, one cycle later.
    logic        refD;       // Reference, one cycle later.
    logic        fbD;        // Feedback, one cycle later.
    logic [23:0] shiftReg;   // Serial shift register.
    logic [8:0]  intVal;     // Integer divide value.
    logic [11:0] fracVal;    // Fractional numerator.
    logic [11:0] modPend;    // Modulus waiting for an integer write.
    logic [11:0] modAct;     // Modulus in use.
    logic [11:0] acc;        // Interpolator accumulator.
    logic [3:0]  rDiv;       // Reference divide value.
    logic [3:0]  rCnt;       // Reference divider count.
    logic [2:0]  muxSel;     // Monitor selection.
    logic        dbl;        // Reference doubler on.
    logic        pdwn;       // Power-down.
    logic        fastLock;   // Fast lock request, held only.
    logic [9:0]  nCnt;       // Feedback divider count.
    logic [9:0]  nLoad;      // Next feedback divide value.
    logic        refOut;     // Detector reference pulse.
    logic        fbOut;      // Detector feedback pulse.
    logic        lockMon;    // Lock indication.
    logic        rfDivMon;   // Scaled feedback for the monitor.
    logic        refDivMon;  // Scaled reference for the monitor.
    logic [7:0]  noise;      // Noise and spur setting, held only.
  } fnd_dev_s;

  fnd_dev_s    st;         // Registered state.
  fnd_dev_s    next_st;    // Next state.
  logic        sckRise;    // Serial clock rose.
  logic        leRise;     // Latch strobe rose.
  logic        refEdge;    // Counted reference edge.
  logic        fbRise;     // Feedback rose.
  logic        refTick;    // Detector reference cycle ends.
  logic [12:0] accSum;     // Accumulator plus numerator, with carry.

  always_comb begin
    sckRise = st.sckS[1] & ~st.sckD;
    leRise  = st.leS[1] & ~st.leD;
    fbRise  = st.fbS[1] & ~st.fbD;
    // With the doubler, both reference edges count.
    refEdge = st.dbl ? (st.refS[1] ^ st.refD) : (st.refS[1] & ~st.refD);
    refTick = refEdge & ~st.pdwn & (st.rCnt <= 4'h1);
    accSum  = {1'b0, st.acc} + {1'b0, st.fracVal};
  end

  // Every pin passes two flip-flops; only the second stage feeds edge logic.
  always_comb begin
    next_st = st;
    next_st.sckS = {st.sckS[0], link.serialClock};
    next_st.datS = {st.datS[0], link.serialData};
    next_st.leS  = {st.leS[0], link.latchStrobe};
    next_st.refS = {st.refS[0], referenceInput};
    next_st.fbS  = {st.fbS[0], feedbackInput};
    next_st.sckD = st.sckS[1];
    next_st.leD  = st.leS[1];
    next_st.refD = st.refS[1];
    next_st.fbD  = st.fbS[1];
    if (sckRise) begin
      next_st.shiftReg = {st.shiftReg[22:0], st.datS[1]};
    end
    // Strobe rise copies the word into the one latch its low bits name.
    if (leRise) begin
      case (st.shiftReg[1:0])
        fnd_pkg::SEL_INTFRAC: begin
          next_st.intVal   = st.shiftReg[fnd_pkg::INT_LSB +: fnd_pkg::INT_W];
          next_st.fracVal  = st.shiftReg[fnd_pkg::FRAC_LSB +: fnd_pkg::FRAC_W];
          next_st.fastLock = st.shiftReg[23];
          next_st.modAct   = st.modPend;
        end
        fnd_pkg::SEL_MODREF: begin
          next_st.modPend = st.shiftReg[fnd_pkg::MODV_LSB +: fnd_pkg::FRAC_W];
          next_st.rDiv    = st.shiftReg[fnd_pkg::RDIV_LSB +: fnd_pkg::RDIV_W];
          next_st.muxSel  = st.shiftReg[fnd_pkg::MUXS_LSB +: fnd_pkg::MUX_W];
        end
        fnd_pkg::SEL_CONTROL: begin
          next_st.dbl  = st.shiftReg[fnd_pkg::DBL_BIT];
          next_st.pdwn = st.shiftReg[fnd_pkg::PDWN_BIT];
        end
        fnd_pkg::SEL_NOISE: begin
          next_st.noise = st.shiftReg[9:2];
        end
        default: next_st.noise = st.noise;
      endcase
    end
    // Reference divider, ratio 1 to 15; zero is treated as one. The detector
    // clock is a one-cycle pulse, since a square wave cannot reach the doubled
    // rate at odd ratios when only reference edges can be counted.
    next_st.refOut = refTick;
    // Power-down stops counting, so the isolated pin makes no detector cycles.
    if (refEdge & ~st.pdwn) begin
      if (st.rCnt <= 4'h1) begin
        next_st.rCnt = (st.rDiv == 4'h0) ? 4'h1 : st.rDiv;
      end else begin
        next_st.rCnt = st.rCnt - 4'h1;
      end
    end
    // Interpolator: one step per detector cycle picks N or N+1.
    if (refTick) begin
      if (accSum >= {1'b0, st.modAct}) begin
        next_st.acc   = 12'(accSum - {1'b0, st.modAct});
        next_st.nLoad = {1'b0, st.intVal} + 10'h001;
      end else begin
        next_st.acc   = accSum[11:0];
        next_st.nLoad = {1'b0, st.intVal};
      end
    end
    // Feedback counter; values below 31 are clamped since they are not allowed.
    if (fbRise) begin
      if (st.nCnt <= 10'h001) begin
        next_st.nCnt  = (st.nLoad < {1'b0, fnd_pkg::INT_MIN}) ?
                        {1'b0, fnd_pkg::INT_MIN} : st.nLoad;
        next_st.fbOut = 1'b1;
      end else begin
        next_st.nCnt  = st.nCnt - 10'h001;
        next_st.fbOut = 1'b0;
      end
      next_st.rfDivMon = st.nCnt <= 10'h001 ? ~st.rfDivMon : st.rfDivMon;
    end
    next_st.refDivMon = st.refOut;
    // Crude lock indication: outside power-down, high whenever the two detector pulses match in a cycle, both high or both low.
    next_st.lockMon = ~st.pdwn & (st.refOut == st.fbOut);
    if (st.pdwn) begin
      next_st.rCnt   = 4'h1;
      next_st.refOut = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st        <= '0;
      st.intVal <= fnd_pkg::INT_RST;
      st.modPend <= fnd_pkg::MOD_RST;
      st.modAct <= fnd_pkg::MOD_RST;
      st.rDiv   <= fnd_pkg::RDIV_RST;
      st.rCnt   <= fnd_pkg::RDIV_RST;
      st.nLoad  <= {1'b0, fnd_pkg::INT_RST};
    end else begin
      st <= next_st;
    end
  end

  // Detector and isolation outputs come straight from state flip-flops; monitorOutput is a muxSel-selected flip-flop, else 0.
  always_comb begin
    detectorRef      = st.refOut;
    detectorFb       = st.fbOut;
    refInputIsolated = st.pdwn;
    case (st.muxSel)
      fnd_pkg::MON_LOCK:  monitorOutput = st.lockMon;
      fnd_pkg::MON_RFDIV: monitorOutput = st.rfDivMon;
      fnd_pkg::MON_REFDV: monitorOutput = st.refDivMon;
      default:            monitorOutput = 1'b0;
    endcase
  end
endmodule

// file: hw/fnd_pkg.sv
// Package of constants and types shared by both ends of the serial load link.
package fnd_pkg;
  localparam int WORD_W    = 24;
  localparam int SEL_W     = 2;
  localparam int INT_W     = 9;
  localparam int FRAC_W    = 12;
  localparam int RDIV_W    = 4;
  localparam int MUX_W     = 3;
  // Field positions inside a shifted word.
  localparam int FRAC_LSB  = 2;
  localparam int INT_LSB   = 14;
  localparam int MODV_LSB  = 2;
  localparam int RDIV_LSB  = 14;
  localparam int MUXS_LSB  = 20;
  localparam int PDWN_BIT  = 3;
  localparam int DBL_BIT   = 11;
  // Latch select codes.
  localparam logic [1:0] SEL_INTFRAC = 2'h0;
  localparam logic [1:0] SEL_MODREF  = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_NOISE   = 2'h3;
  // Monitor selections.
  localparam logic [2:0] MON_LOCK  = 3'h6;
  localparam logic [2:0] MON_RFDIV = 3'h2;
  localparam logic [2:0] MON_REFDV = 3'h4;
  // Limits and reset values.
  localparam logic [8:0]  INT_MIN   = 9'h01f;
  localparam logic [11:0] MOD_MIN   = 12'h002;
  localparam logic [8:0]  INT_RST   = 9'h01f;
  localparam logic [11:0] MOD_RST   = 12'h002;
  localparam logic [3:0]  RDIV_RST  = 4'h1;
  // Host serial timing: half period and strobe width in system cycles.
  localparam int SCK_HALF_NS = 25;
  localparam int CLK_NS      = 8;
  localparam int SCK_HALF_CY = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_CNT    = 8;
  typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_STROBE} fnd_host_e;
endpackage

// file: hw/fnd_link_if.sv
// Interface carrying the three-wire serial load link.
`timescale 1ns/10ps
interface fnd_link_if;
  logic serialClock;
  logic serialData;
  logic latchStrobe;
  modport device (input serialClock, input serialData, input latchStrobe);
  modport host (output serialClock, output serialData, output latchStrobe);
endinterface

// file: hw/fnd_host.sv
// Host end: shifts 24-bit words out on the three-wire link.
`timescale 1ns/10ps
module fnd_host (
  input  wire logic        sys_clk,     // System clock.
  input  wire logic        arst_n,      // Asynchronous reset, active low.
  fnd_link_if.host         link,        // Serial load link.
  input  wire logic        cmdWrite,    // Pulse: send cmdWord.
  input  wire logic [23:0] cmdWord,     // Word to send, select bits in [1:0].
  output logic             busy         // High while a word is in flight.
);
  typedef struct packed {
    fnd_pkg::fnd_host_e state;
    logic [23:0] word;
    logic [4:0]  bitCnt;
    logic [3:0]  tmr;
    logic        sck, dat, le;
  } fnd_host_s;

  fnd_host_s st, next_st;

  // Each phase lasts SCK_HALF_CY+1 cycles to keep high, low and setup minima.
  always_comb begin
    next_st = st;
    case (st.state)
      fnd_pkg::HS_IDLE: begin
        next_st.le = 1'b0;
        if (cmdWrite) begin
          next_st.word   = cmdWord;
          next_st.dat    = cmdWord[23];
          next_st.bitCnt = 5'h17;
          next_st.tmr    = 4'(fnd_pkg::SCK_HALF_CY);
          next_st.state  = fnd_pkg::HS_LOW;
        end
      end
      fnd_pkg::HS_LOW: begin
        if (st.tmr == 4'h0) begin
          next_st.sck   = 1'b1;
          next_st.tmr   = 4'(fnd_pkg::SCK_HALF_CY);
          next_st.state = fnd_pkg::HS_HIGH;
        end else next_st.tmr = st.tmr - 4'h1;
      end
      fnd_pkg::HS_HIGH: begin
        if (st.tmr == 4'h0) begin
          next_st.sck = 1'b0;
          next_st.tmr = 4'(fnd_pkg::SCK_HALF_CY);
          if (st.bitCnt == 5'h0) begin
            next_st.state = fnd_pkg::HS_STROBE;
          end else begin
            next_st.word   = {st.word[22:0], 1'b0};
            next_st.dat    = st.word[22];
            next_st.bitCnt = st.bitCnt - 5'h1;
            next_st.state  = fnd_pkg::HS_LOW;
          end
        end else next_st.tmr = st.tmr - 4'h1;
      end
      fnd_pkg::HS_STROBE: begin
        // Strobe goes high only after the last bit, then holds its width.
        if (st.tmr == 4'h0) begin
          if (st.le) begin
            next_st.state = fnd_pkg::HS_IDLE;
            next_st.le    = 1'b0;
          end else begin
            next_st.le  = 1'b1;
            next_st.tmr = 4'(fnd_pkg::SCK_HALF_CY);
          end
        end else next_st.tmr = st.tmr - 4'h1;
      end
      default: next_st.state = fnd_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    link.serialClock = st.sck;
    link.serialData  = st.dat;
    link.latchStrobe = st.le;
    busy = (st.state != fnd_pkg::HS_IDLE);
  end
endmodule

// file: verif/fnd_link_sva.sv
// Checker for the three-wire serial load link.
`timescale 1ns/10ps
module fnd_link_sva (
  input wire logic sys_clk,     // System clock.
  input wire logic arst_n,      // Reset, active low.
  input wire logic serialClock, // Serial clock wire.
  input wire logic serialData,  // Serial data wire.
  input wire logic latchStrobe  // Latch strobe wire.
);
  logic [4:0] bitCount;
  logic       prevSck;
  logic       prevLe;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Count bits since the last strobe; a short word would latch stale bits.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitCount <= 5'h00;
      prevSck <= 1'b0;
      prevLe <= 1'b0;
    end else begin
      prevSck <= serialClock;
      prevLe <= latchStrobe;
      if (latchStrobe && !prevLe) begin
        bitCount <= 5'h00;
      end else if (serialClock && !prevSck) begin
        bitCount <= bitCount + 5'h01;
      end
    end
  end
  data_at_rise_a: assert property ($rose(serialClock) |-> $stable(serialData))
    else $error("Data moved at serial clock rise");
  data_hold_a: assert property (serialClock && $past(serialClock) |-> $stable(serialData))
    else $error("Data moved while serial clock high");
  strobe_quiet_a: assert property (latchStrobe |-> !serialClock)
    else $error("Serial clock high during strobe");
  strobe_width_a: assert property ($rose(latchStrobe) |-> latchStrobe[*4])
    else $error("Strobe too short");
  sck_high_a: assert property ($rose(serialClock) |-> serialClock[*4])
    else $error("Serial clock high too short");
  sck_low_a: assert property ($fell(serialClock) |-> !serialClock[*4])
    else $error("Serial clock low too short");
  word_count_a: assert property (latchStrobe && !prevLe |-> bitCount == 5'h18)
    else $error("Strobe not after 24 bits");
  bit_limit_a: assert property (serialClock && !prevSck |-> bitCount < 5'h18)
    else $error("More than 24 bits in a word");
  cover property ($rose(latchStrobe));
  cover property ($rose(serialClock) && serialData);
  cover property (latchStrobe && !prevLe && bitCount == 5'h18);
endmodule

// file: verif/fracn_divider_serial_load_test.sv
// Testbench joining host and device ends over the serial load link.
`timescale 1ns/10ps
module fracn_divider_serial_load_test;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cmdWrite = 1'b0;
  logic [23:0] cmdWord = 24'h0;
  logic [2:0]  pinCount = 3'h0;
  logic        referenceInput = 1'b0;
  logic        feedbackInput = 1'b0;
  logic        busy;
  logic        detectorRef;
  logic        detectorFb;
  logic        monitorOutput;
  logic        refInputIsolated;
  logic [23:0] capWord = 24'h0;
  int          capCount = 0;
  int          errCount = 0;
  int          numChecks = 0;
  int          cycles = 0;
  fnd_link_if linkBus ();
  fnd_host fnd_host_i (.sys_clk(sys_clk), .arst_n(arst_n), .link(linkBus),
    .cmdWrite(cmdWrite), .cmdWord(cmdWord), .busy(busy));
  fnd_device fnd_device_i (.sys_clk(sys_clk), .arst_n(arst_n), .link(linkBus),
    .referenceInput(referenceInput), .feedbackInput(feedbackInput), .detectorRef(detectorRef),
    .detectorFb(detectorFb), .monitorOutput(monitorOutput), .refInputIsolated(refInputIsolated));
  fnd_link_sva fnd_link_sva_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .serialClock(linkBus.serialClock), .serialData(linkBus.serialData),
    .latchStrobe(linkBus.latchStrobe));
  always #4 sys_clk = ~sys_clk;
  // Reference runs at an eighth and feedback at a quarter of the system clock.
  always @(posedge sys_clk) begin
    pinCount <= pinCount + 3'h1;
    feedbackInput <= pinCount[1];
    referenceInput <= pinCount[2];
  end
  // Shadow the wire so each sent word is compared bit for bit.
  always @(posedge linkBus.serialClock) begin
    capWord <= {capWord[22:0], linkBus.serialData};
    capCount <= capCount + 1;
  end
  // A hang would stall the run, so a ceiling ends it.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errCount++;
      wrapUp();
    end
  end
  task automatic wrapUp();
    $display("Checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got,
                     input int tol);
    numChecks++;
    if ($isunknown(got) ||
        (tol == 0 ? got !== exp : (got > exp + tol || got + tol < exp))) begin
      errCount++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  function automatic logic [23:0] wMod(logic [2:0] mx, logic [3:0] r, logic [11:0] md);
    return {1'b0, mx, 2'b00, r, md, fnd_pkg::SEL_MODREF};
  endfunction
  function automatic logic [23:0] wInt(logic [8:0] n, logic [11:0] fr);
    return {1'b0, n, fr, fnd_pkg::SEL_INTFRAC};
  endfunction
  function automatic logic [23:0] wCtl(logic d, logic pd);
    return {12'h000, d, 7'h00, pd, 1'b0, fnd_pkg::SEL_CONTROL};
  endfunction
  task automatic send(input logic [23:0] w);
    int n0;
    n0 = capCount;
    cmdWord <= w;
    cmdWrite <= 1'b1;
    @(posedge sys_clk);
    cmdWrite <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge sys_clk);
    chk("host idle", 24'h0, {23'h0, busy}, 0);
    repeat (6) @(posedge sys_clk);
    chk("word on wire", w, capWord, 0);
    chk("bits per word", 24'h18, 24'(capCount - n0), 0);
  endtask
  // Rising edges of the two detector outputs and the monitor output over a window of system cycles.
  task automatic count(input int n, output logic [23:0] r, output logic [23:0] f,
                       output logic [23:0] m);
    logic pr, pf, pm;
    r = 24'h0;
    f = 24'h0;
    m = 24'h0;
    repeat (n) begin
      pr = detectorRef;
      pf = detectorFb;
      pm = monitorOutput;
      @(posedge sys_clk);
      r += 24'(detectorRef === 1'b1 && pr === 1'b0);
      f += 24'(detectorFb === 1'b1 && pf === 1'b0);
      m += 24'(monitorOutput === 1'b1 && pm === 1'b0);
    end
  endtask
  // Detector period is 8*R/(1+D) cycles, so 960 cycles give 40 rises at R=3.
  task automatic testRefDiv();
    logic [23:0] r, f, m;
    send(wMod(3'h0, 4'h3, 12'h002));
    send(wInt(9'h01f, 12'h000));
    send(wCtl(1'b0, 1'b0));
    count(960, r, f, m);
    chk("ref rises", 24'h28, r, 1);
    chk("monitor off", 24'h0, m, 0);
    send(wCtl(1'b1, 1'b0));
    count(960, r, f, m);
    chk("doubled rises", 24'h50, r, 1);
    send(wCtl(1'b0, 1'b0));
    send(24'hffffff);
    count(960, r, f, m);
    chk("noise write leaves divider", 24'h28, r, 1);
    $display("Reference divider test done");
  endtask
  task automatic testPowerDown();
    logic [23:0] r, f, m;
    send(wCtl(1'b0, 1'b1));
    chk("isolated", 24'h1, {23'h0, refInputIsolated}, 0);
    count(480, r, f, m);
    chk("ref gated", 24'h0, r, 0);
    send(wCtl(1'b0, 1'b0));
    chk("restored", 24'h0, {23'h0, refInputIsolated}, 0);
    count(480, r, f, m);
    chk("ref back", 24'h14, r, 1);
    $display("Power-down test done");
  endtask
  task automatic testMonitor();
    logic [23:0] r, f, m;
    // Scaled reference shows one rise per detector cycle: 480 / 24 = 20.
    send(wMod(fnd_pkg::MON_REFDV, 4'h3, 12'h002));
    count(480, r, f, m);
    chk("monitor ref", 24'h14, m, 1);
    // Scaled feedback toggles every 31 feedback rises: one or two rises.
    send(wMod(fnd_pkg::MON_RFDIV, 4'h3, 12'h002));
    count(480, r, f, m);
    chk("monitor rf", 24'h2, m, 1);
    send(wMod(fnd_pkg::MON_LOCK, 4'h3, 12'h002));
    send(wCtl(1'b0, 1'b1));
    chk("lock off in power-down", 24'h0, {23'h0, monitorOutput}, 0);
    send(wCtl(1'b0, 1'b0));
    count(480, r, f, m);
    chk("lock shown", 24'h1, {23'h0, m != 24'h0}, 0);
    $display("Monitor test done");
  endtask
  // 5952 feedback rises per window: 189 pulses at 31.5, 192 at 31.
  task automatic testFraction();
    logic [23:0] r, f, m;
    send(wMod(3'h0, 4'hf, 12'h002));
    send(wInt(9'h01f, 12'h001));
    count(23808, r, f, m);
    chk("half step", 24'hbd, f, 1);
    send(wMod(3'h0, 4'hf, 12'hfff));
    count(23808, r, f, m);
    chk("modulus held", 24'hbd, f, 1);
    send(wInt(9'h01f, 12'h000));
    count(23808, r, f, m);
    chk("integer only", 24'hc0, f, 1);
    $display("Fraction test done");
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    testRefDiv();
    testPowerDown();
    testMonitor();
    testFraction();
    wrapUp();
  end
endmodule
